// file: sim/sdram_pin_control_tb_top.sv
// Self-checking testbench for the SDRAM pin control block
`timescale 1ns/1ps
`include "spc_defs.vh"
module sdram_pin_control_tb_top;
  reg clock = 1'h0, rst_n = 1'h0, bus_master = 1'h1, bus_32bit = 1'h0;
  reg op_single_word = 1'h0, host_bus_request = 1'h0;
  reg outstanding_busy = 1'h0;
  wire gnt_oe;
  reg [2:0] op_req = 3'h0;
  reg [31:0] op_addr = 32'h0;
  wire op_accept, sel_oe, ras_n, cas_n, we_n, lm, hm, a10, cke, pins_oe, gnt;
  wire [3:0] sel_n, sel_pin;
  wire [2:0] cmd_pin;
  integer err_total = 0, total_checks = 0, i;
  always #2 clock = ~clock;
  spc_sdram_pin_control uut (.clock, .rst_n, .bus_master, .bus_32bit,
    .op_req, .op_single_word, .op_addr, .host_bus_request,
    .outstanding_busy, .op_accept, .sdram_bank_select_n_o(sel_n),
    .sdram_bank_select_oe(sel_oe), .row_strobe_n_o(ras_n),
    .column_strobe_n_o(cas_n), .sdram_write_enable_n_o(we_n),
    .low_half_data_mask_o(lm), .high_half_data_mask_o(hm),
    .sdram_addr_bit10_o(a10), .sdram_clock_enable_o(cke),
    .sdram_pins_oe(pins_oe), .host_bus_grant_o(gnt),
    .host_bus_grant_oe(gnt_oe));
  spc_sdram_mdl mdl (.sel_oe(sel_oe), .pins_oe(pins_oe), .sel_n(sel_n),
    .cmd_n({ras_n, cas_n, we_n}), .sel_pin(sel_pin), .cmd_pin(cmd_pin));
  ////////////////////////////////////////
  task chk(input [31:0] seen, input [31:0] exp, input string nm);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One request, dropped at the taking edge so it is not taken twice
  task op(input [2:0] o, input [31:0] a, input w, input s);
    @(posedge clock);
    op_req <= o;
    op_addr <= a;
    bus_32bit <= w;
    op_single_word <= s;
    @(posedge clock);
    op_req <= 3'h0;
    #1;
  endtask
  task t_rw;
    reg [31:0] a;
    for (i = 0; i < 8; i = i + 1) begin
      a = {2'h1, i[1:0], 17'h0, i[0], 9'h0, i[0]};
      op(3'h2, a, i[2], i[1]);
      chk(op_accept, 1, "accept");
      chk(sel_n, 4'(~(4'h1 << i[1:0])), "select");
      chk({ras_n, cas_n, we_n, a10}, {`SPC_CMD_ACT, i[0]}, "row");
      @(posedge clock);
      #1;
      chk({ras_n, cas_n, we_n}, `SPC_CMD_WRITE, "write");
      chk(sel_n, 4'(~(4'h1 << i[1:0])), "col select");
      chk({lm, hm}, {i[0] & !i[2],
        i[2] | (i[1] & !i[0])}, "mask");
      op(3'h1, a, i[2], i[1]);
      chk({ras_n, cas_n, we_n}, `SPC_CMD_ACT, "read row");
      @(posedge clock);
      #1;
      chk({ras_n, cas_n, we_n, lm, hm},
        {`SPC_CMD_READ, 2'h0}, "read");
    end
  endtask
  task t_oth;
    for (i = 3; i < 6; i = i + 1) begin
      op(i[2:0], 32'h4000_0000, 1'h0, 1'h0);
      chk({ras_n, cas_n, we_n}, i == 3 ? `SPC_CMD_REF : i == 4 ?
        `SPC_CMD_PRE : `SPC_CMD_MRS, "other");
    end
    op(3'h1, 32'h4c00_0000, 1'h0, 1'h0);
    chk({sel_n, ras_n, cas_n, we_n},
      {4'hf, `SPC_CMD_NOP}, "reserved");
  endtask
  task t_pwr;
    op(3'h6, 32'h4000_0000, 1'h0, 1'h0);
    chk({cke, ras_n, cas_n, we_n}, {1'h0, `SPC_CMD_REF}, "self");
    op(3'h1, 32'h4000_0000, 1'h0, 1'h0);
    chk({op_accept, cke, cas_n}, 3'h7, "wake");
    op(3'h7, 32'h4000_0000, 1'h0, 1'h0);
    chk(cke, 0, "suspend");
    op(3'h1, 32'h4000_0000, 1'h0, 1'h0);
    chk(cke, 1, "resume");
  endtask
  task t_host;
    @(posedge clock);
    outstanding_busy <= 1'h1;
    host_bus_request <= 1'h1;
    repeat (3) @(posedge clock);
    #1;
    chk({gnt, cke}, 2'h1, "busy hold");
    @(posedge clock);
    outstanding_busy <= 1'h0;
    for (i = 0; i < 8 && gnt !== 1'h1; i = i + 1) @(posedge clock);
    #1;
    chk({gnt_oe, gnt, pins_oe, sel_pin, cmd_pin}, 10'h37f, "granted");
    op(3'h1, 32'h4000_0000, 1'h0, 1'h0);
    chk({op_accept, gnt}, 2'h1, "ignored");
    @(posedge clock);
    host_bus_request <= 1'h0;
    repeat (3) @(posedge clock);
    #1;
    chk({gnt, cke, pins_oe}, 3'h3, "released");
  endtask
  task t_slave;
    @(posedge clock);
    bus_master <= 1'h0;
    op(3'h1, 32'h4000_0000, 1'h0, 1'h0);
    chk({op_accept, sel_oe, gnt_oe, sel_pin}, 7'hf, "slave");
    @(posedge clock);
    bus_master <= 1'h1;
  endtask
  task complete_run;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clock);
    rst_n <= 1'h1;
    repeat (2) @(posedge clock);
    t_rw;
    t_oth;
    t_pwr;
    t_host;
    t_slave;
    complete_run;
  end
  // Whole run is under 200 cycles, so this margin only trips on a hang
  initial begin
    repeat (2000) @(posedge clock);
    err_total = err_total + 1;
    complete_run;
  end
endmodule

// file: sim/spc_chk.sv
// Assertion checker for the SDRAM pin control block
`timescale 1ns/1ps
`include "spc_defs.vh"
module spc_chk (
  input wire clock, input wire rst_n, input wire bus_master,
  input wire bus_32bit, input wire [2:0] op_req, input wire op_single_word,
  input wire [31:0] op_addr, input wire op_accept,
  input wire [3:0] sdram_bank_select_n_o, input wire sdram_bank_select_oe,
  input wire row_strobe_n_o, input wire column_strobe_n_o,
  input wire sdram_write_enable_n_o, input wire low_half_data_mask_o,
  input wire high_half_data_mask_o, input wire sdram_clock_enable_o,
  input wire sdram_pins_oe, input wire host_bus_grant_o
);
  wire [2:0] cmd = {row_strobe_n_o, column_strobe_n_o, sdram_write_enable_n_o};
  wire in_sp = op_addr[31:30] == 2'h1 && op_addr[27:26] != 2'h3;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // A wake-up acceptance issues no command, so it is excluded here
  sequence s_take;
    op_accept && $past(sdram_clock_enable_o);
  endsequence
  sequence s_rw;
    s_take ##0 $past(in_sp) && $past(op_req) inside {3'h1, 3'h2};
  endsequence
  ////////////////////////////////////////
  property p_sel;
    s_rw |-> sdram_bank_select_n_o == ~(4'h1 << $past(op_addr[29:28]));
  endproperty
  a_sel: assert property (p_sel) else $error("select");
  property p_oe;
    !bus_master |=> !sdram_bank_select_oe;
  endproperty
  a_oe: assert property (p_oe) else $error("select drive");
  property p_rw;
    s_rw |-> cmd == `SPC_CMD_ACT ##1 cmd ==
      ($past(op_req, 2) == 3'h1 ? `SPC_CMD_READ : `SPC_CMD_WRITE);
  endproperty
  a_rw: assert property (p_rw) else $error("rw cmd");
  property p_oth;
    s_take ##0 $past(op_req) inside {3'h3, 3'h4, 3'h5} |-> cmd ==
      ($past(op_req) == 3'h3 ? `SPC_CMD_REF : $past(op_req) == 3'h4 ?
      `SPC_CMD_PRE : `SPC_CMD_MRS);
  endproperty
  a_oth: assert property (p_oth) else $error("other cmd");
  property p_msk;
    column_strobe_n_o || cmd == `SPC_CMD_READ |->
      !low_half_data_mask_o && !high_half_data_mask_o;
  endproperty
  a_msk: assert property (p_msk) else $error("mask idle");
  property p_wrm;
    s_rw ##0 $past(op_req) == 3'h2 |=> low_half_data_mask_o ==
      ($past(op_addr[0], 2) && !$past(bus_32bit, 2)) &&
      high_half_data_mask_o == ($past(bus_32bit, 2) ||
      ($past(op_single_word, 2) && !$past(op_addr[0], 2)));
  endproperty
  a_wrm: assert property (p_wrm) else $error("write mask");
  property p_cke;
    s_take ##0 $past(op_req) >= 3'h6 |-> !sdram_clock_enable_o;
  endproperty
  a_cke: assert property (p_cke) else $error("cke");
  property p_hbg;
    $rose(host_bus_grant_o) |-> $past(cmd) == `SPC_CMD_REF &&
      !sdram_pins_oe && !sdram_bank_select_oe && !sdram_clock_enable_o;
  endproperty
  a_hbg: assert property (p_hbg) else $error("grant");
endmodule
bind spc_sdram_pin_control spc_chk u_chk (.clock, .rst_n, .bus_master,
  .bus_32bit, .op_req, .op_single_word, .op_addr, .op_accept,
  .sdram_bank_select_n_o, .sdram_bank_select_oe, .row_strobe_n_o,
  .column_strobe_n_o, .sdram_write_enable_n_o, .low_half_data_mask_o,
  .high_half_data_mask_o, .sdram_clock_enable_o, .sdram_pins_oe,
  .host_bus_grant_o);

// file: sim/spc_sdram_mdl.sv
// SDRAM side of the select and command lines
`timescale 1ns/1ps
module spc_sdram_mdl (
  input wire sel_oe,
  input wire pins_oe,
  input wire [3:0] sel_n,
  input wire [2:0] cmd_n,
  output wire [3:0] sel_pin,
  output wire [2:0] cmd_pin
);
  // Floated lines settle at the pull-up, which reads as deselect and NOP
  assign sel_pin = sel_oe ? sel_n : 4'hf;
  assign cmd_pin = pins_oe ? cmd_n : 3'h7;
endmodule

// file: verilog/spc_defs.vh
// Constants for the SDRAM pin control block
`ifndef SPC_DEFS_VH
`define SPC_DEFS_VH

// SDRAM space: top two address bits
`define SPC_SPACE_HI 31
`define SPC_SPACE_LO 30
`define SPC_SPACE_CODE 2'h1
// Bank select decode bits within SDRAM space
`define SPC_BANK_HI 29
`define SPC_BANK_LO 28
// Reserved region inside SDRAM space: bits 27:26 all ones
`define SPC_RSV_HI 27
`define SPC_RSV_LO 26
`define SPC_RSV_CODE 2'h3
// Word address bit that picks the half of a 64-bit bus
`define SPC_WORD_BIT 0
// Row address bit carried on the dedicated bit-10 pin
`define SPC_A10_BIT 10

// Command codes {row strobe, column strobe, write enable}, active low
`define SPC_CMD_NOP 3'h7
`define SPC_CMD_ACT 3'h3
`define SPC_CMD_READ 3'h5
`define SPC_CMD_WRITE 3'h4
`define SPC_CMD_PRE 3'h2
`define SPC_CMD_REF 3'h1
`define SPC_CMD_MRS 3'h0

// Operation request codes
`define SPC_OP_NONE 3'h0
`define SPC_OP_READ 3'h1
`define SPC_OP_WRITE 3'h2
`define SPC_OP_REFRESH 3'h3
`define SPC_OP_PRECHARGE 3'h4
`define SPC_OP_MODE 3'h5
`define SPC_OP_SELF_REF 3'h6
`define SPC_OP_SUSPEND 3'h7

`endif

// file: verilog/spc_sdram_pin_control.v
// SDRAM command, select, mask and clock-enable pin driver
`timescale 1ns/1ps
`include "spc_defs.vh"

// Notes on behaviour
// [RL1] One bank select low on each read or write in SDRAM space, not reserved; one accepted to wake from self-refresh or suspend selects none.
// [RL2] Only the bus master drives bank selects; others leave them floating.
// [RL3] Row strobe low marks a valid row address in reads and writes.
// [RL4] Column strobe low marks a valid column address in reads and writes.
// [RL5] Other operations encode their command on row, column, write enable.
// [RL6] With column strobe low, write enable low on writes, high on reads.
// [RL7] Masks stay low on reads; they matter only with column strobe low.
// [RL8] Writes to odd words on a 64-bit bus raise the low-half mask.
// [RL9] High-half mask on single even-word writes, or always on 32-bit bus.
// [RL10] A dedicated bit-10 pin allows refresh while others use the bus.
// [RL11] Clock enable drops for self-refresh and suspend, rises on exit.
// [RL12] On host grant, self-refresh and float outputs until request ends.
// [RL13] Bank select chosen by decoding two address bits in SDRAM space.
module spc_sdram_pin_control #(
  parameter ADDR_WIDTH = 32
) (
  input wire clock,
  input wire rst_n,
  input wire bus_master,
  input wire bus_32bit,
  input wire [2:0] op_req,
  input wire op_single_word,
  input wire [ADDR_WIDTH-1:0] op_addr,
  input wire host_bus_request,
  input wire outstanding_busy,
  output reg op_accept,
  output reg [3:0] sdram_bank_select_n_o,
  output reg sdram_bank_select_oe,
  output reg row_strobe_n_o,
  output reg column_strobe_n_o,
  output reg sdram_write_enable_n_o,
  output reg low_half_data_mask_o,
  output reg high_half_data_mask_o,
  output reg sdram_addr_bit10_o,
  output reg sdram_clock_enable_o,
  output reg sdram_pins_oe,
  output reg host_bus_grant_o,
  output reg host_bus_grant_oe
);

  //////////////////////////////////////////////////////////////////////////
  // Reset release and state codes

  localparam ST_RUN = 3'h0;
  localparam ST_SUSP = 3'h1;
  localparam ST_SELF = 3'h2;
  localparam ST_HOST = 3'h3;
  localparam ST_COL = 3'h4;

  reg rst_meta_n;
  reg rst_sync_n;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Request decode

  reg [2:0] state;
  reg [2:0] next_state;
  reg [2:0] col_cmd;
  reg [3:0] col_sel_n;
  reg col_low_half_data_mask;
  reg col_high_half_data_mask;
  reg [2:0] next_cmd;
  reg [3:0] next_sel_n;
  reg next_low_half_data_mask;
  reg next_high_half_data_mask;
  reg next_a10;
  reg next_accept;
  reg in_space;

  wire is_rw = (op_req == `SPC_OP_READ) || (op_req == `SPC_OP_WRITE);
  wire is_write = (op_req == `SPC_OP_WRITE);
  wire wr_low_half_data_mask = op_addr[`SPC_WORD_BIT] && !bus_32bit;
  wire wr_high_half_data_mask = bus_32bit || (op_single_word && !op_addr[`SPC_WORD_BIT]);

  always @* begin
    next_state = state;
    next_cmd = `SPC_CMD_NOP;
    next_sel_n = 4'hf;
    next_low_half_data_mask = 1'b0;
    next_high_half_data_mask = 1'b0;
    next_a10 = 1'b0;
    next_accept = 1'b0;
    in_space = (op_addr[`SPC_SPACE_HI:`SPC_SPACE_LO] == `SPC_SPACE_CODE) &&
      (op_addr[`SPC_RSV_HI:`SPC_RSV_LO] != `SPC_RSV_CODE);
    case (state)
      ST_RUN: begin
        // Grant waits for the outstanding transaction to finish
        if (host_bus_request && bus_master && !outstanding_busy) begin
          next_cmd = `SPC_CMD_REF; // [RL12]
          next_sel_n = 4'h0;
          next_state = ST_SELF;
        end else if (!bus_master || op_req == `SPC_OP_NONE) begin
          next_cmd = `SPC_CMD_NOP;
        end else if (is_rw) begin
          next_accept = 1'b1;
          if (in_space) begin
            // Row first, column on the next cycle
            next_cmd = `SPC_CMD_ACT; // [RL3]
            next_sel_n = ~(4'h1 <<
              op_addr[`SPC_BANK_HI:`SPC_BANK_LO]); // [RL1] [RL13]
            next_a10 = op_addr[`SPC_A10_BIT]; // [RL10]
            next_state = ST_COL;
          end
        end else begin
          next_accept = 1'b1;
          next_sel_n = 4'h0;
          case (op_req)
            `SPC_OP_REFRESH: begin
              // Refresh needs no address bus, only the bit-10 pin
              next_cmd = `SPC_CMD_REF; // [RL10]
            end
            `SPC_OP_PRECHARGE: begin
              next_cmd = `SPC_CMD_PRE; // [RL5]
              next_a10 = 1'b1; // [RL10]
            end
            `SPC_OP_MODE: next_cmd = `SPC_CMD_MRS; // [RL5]
            `SPC_OP_SELF_REF: begin
              next_cmd = `SPC_CMD_REF; // [RL11]
              next_state = ST_SELF;
            end
            `SPC_OP_SUSPEND: begin
              next_sel_n = 4'hf;
              next_state = ST_SUSP; // [RL11]
            end
            default: next_sel_n = 4'hf;
          endcase
        end
      end
      ST_SUSP, ST_SELF: begin
        if (state == ST_SELF && host_bus_request && bus_master &&
            host_bus_grant_o == 1'b0) begin
          next_state = ST_HOST; // [RL12]
        end else if (bus_master && op_req != `SPC_OP_NONE &&
                     !host_bus_request) begin
          next_state = ST_RUN; // [RL11]
          next_accept = 1'b1;
        end
      end
      ST_COL: begin
        // Column half; bit 10 low, so no automatic precharge
        next_cmd = col_cmd; // [RL4] [RL6]
        next_sel_n = col_sel_n;
        next_low_half_data_mask = col_low_half_data_mask; // [RL8]
        next_high_half_data_mask = col_high_half_data_mask; // [RL9]
        next_state = ST_RUN;
      end
      ST_HOST: begin
        if (!host_bus_request) begin
          next_state = ST_RUN; // [RL12]
        end
      end
      default: next_state = ST_RUN;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Pin registers

  always @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state <= ST_RUN;
      col_cmd <= `SPC_CMD_NOP;
      col_sel_n <= 4'hf;
      col_low_half_data_mask <= 1'b0;
      col_high_half_data_mask <= 1'b0;
      op_accept <= 1'b0;
      sdram_bank_select_n_o <= 4'hf;
      sdram_bank_select_oe <= 1'b0;
      row_strobe_n_o <= 1'b1;
      column_strobe_n_o <= 1'b1;
      sdram_write_enable_n_o <= 1'b1;
      low_half_data_mask_o <= 1'b0;
      high_half_data_mask_o <= 1'b0;
      sdram_addr_bit10_o <= 1'b0;
      sdram_clock_enable_o <= 1'b1;
      sdram_pins_oe <= 1'b0;
      host_bus_grant_o <= 1'b0;
      host_bus_grant_oe <= 1'b0;
    end else begin
      state <= next_state;
      if (next_state == ST_COL) begin
        col_cmd <= is_write ? `SPC_CMD_WRITE : `SPC_CMD_READ;
        col_sel_n <= next_sel_n;
        col_low_half_data_mask <= is_write && wr_low_half_data_mask; // [RL8]
        col_high_half_data_mask <= is_write && wr_high_half_data_mask; // [RL9]
      end
      op_accept <= next_accept;
      sdram_bank_select_n_o <= next_sel_n;
      {row_strobe_n_o, column_strobe_n_o,
        sdram_write_enable_n_o} <= next_cmd; // [RL4] [RL5] [RL6]
      // Masks are zero whenever the command is not a write
      low_half_data_mask_o <= next_low_half_data_mask; // [RL7]
      high_half_data_mask_o <= next_high_half_data_mask; // [RL7]
      sdram_addr_bit10_o <= next_a10;
      // Clock enable low in both low-power states and while host owns bus
      sdram_clock_enable_o <= (next_state == ST_RUN) ||
        (next_state == ST_COL); // [RL11]
      // Only the master drives; host grant floats the SDRAM pins
      sdram_bank_select_oe <= bus_master &&
        (next_state != ST_HOST); // [RL2] [RL12]
      sdram_pins_oe <= bus_master && (next_state != ST_HOST); // [RL12]
      host_bus_grant_o <= (next_state == ST_HOST); // [RL12]
      host_bus_grant_oe <= bus_master;
    end
  end

endmodule
